// *** rtl/iolg_pkg.sv ***
// shared constants, types and helpers for the pin i/o logic cell
package iolg_pkg;

  // ****************************************************************
  // delay line
  // ****************************************************************
  localparam int          DLY_STEPS   = 128;
  localparam int          DLY_STEP_PS = 30;
  localparam int          DLY_W       = 7;
  localparam int          PS_W        = 12;
  localparam logic [6:0]  DLY_MAX     = 7'h7f;
  localparam logic [6:0]  DLY_MIN     = 7'h00;
  localparam logic [6:0]  DLY_RST     = 7'h00;

  // ****************************************************************
  // gearbox sizing and ratios
  // ****************************************************************
  localparam int          GB_W        = 16;
  localparam int          CNT_W       = 4;
  localparam logic [4:0]  RATIO_ONE   = 5'h01;
  localparam logic [4:0]  RATIO_DDR   = 5'h02;
  localparam logic [4:0]  RATIO_GB4   = 5'h04;
  localparam logic [4:0]  RATIO_GB7   = 5'h07;
  localparam logic [4:0]  RATIO_GB8   = 5'h08;
  localparam logic [4:0]  RATIO_GB10  = 5'h0a;
  localparam logic [4:0]  RATIO_GB16  = 5'h10;
  localparam logic        RST_BIT     = 1'b0;
  localparam logic [15:0] RST_WORD    = 16'h0000;

  // ****************************************************************
  // configuration types
  // ****************************************************************
  typedef enum logic [7:0] {
    MD_BASIC = 8'h01,
    MD_SDR   = 8'h02,
    MD_DDR   = 8'h04,
    MD_GB4   = 8'h08,
    MD_GB7   = 8'h10,
    MD_GB8   = 8'h20,
    MD_GB10  = 8'h40,
    MD_GB16  = 8'h80
  } iolg_mode_t;

  typedef enum logic [3:0] {
    DIR_IN    = 4'h1,
    DIR_OUT   = 4'h2,
    DIR_BIDIR = 4'h4,
    DIR_TRI   = 4'h8
  } iolg_dir_t;

  typedef enum logic [4:0] {
    SR_NONE = 5'h01,
    SR_SSET = 5'h02,
    SR_SRST = 5'h04,
    SR_ASET = 5'h08,
    SR_ARST = 5'h10
  } iolg_sr_t;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [4:0] ratio_of(input iolg_mode_t m);
    case (m)
      MD_DDR:  ratio_of = RATIO_DDR;
      MD_GB4:  ratio_of = RATIO_GB4;
      MD_GB7:  ratio_of = RATIO_GB7;
      MD_GB8:  ratio_of = RATIO_GB8;
      MD_GB10: ratio_of = RATIO_GB10;
      MD_GB16: ratio_of = RATIO_GB16;
      default: ratio_of = RATIO_ONE;
    endcase
  endfunction : ratio_of

  function automatic logic [15:0] take_word(input logic [15:0] sh, input logic [4:0] r);
    take_word = sh >> (5'h10 - r);
  endfunction : take_word

  function automatic logic [11:0] dly_ps(input logic [6:0] code);
    dly_ps = 12'(code * DLY_STEP_PS);
  endfunction : dly_ps

endpackage : iolg_pkg

// *** rtl/iolg_pin_reg.sv ***
// one configurable pin storage element: enable polarity, edge, set/reset, latch
module iolg_pin_reg
  import iolg_pkg::*;
(
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     nrst_i,
  // data
  input  wire logic     d_i,
  output logic          q_o,
  // configuration
  input  wire logic     ce_i,
  input  wire logic     ce_act_high_i,
  input  wire logic     fall_edge_i,
  input  wire logic     sr_i,
  input  wire iolg_sr_t sr_mode_i,
  input  wire logic     latch_i
);

  logic neg_reg;
  logic q_reg;
  logic q_next;
  wire  ce_on  = (ce_i == ce_act_high_i);
  wire  sel_d  = (fall_edge_i && !latch_i) ? neg_reg : d_i;
  wire  a_set  = sr_i && (sr_mode_i == SR_ASET);
  wire  a_rst  = sr_i && (sr_mode_i == SR_ARST);
  wire  s_set  = sr_i && (sr_mode_i == SR_SSET);
  wire  s_rst  = sr_i && (sr_mode_i == SR_SRST);

  // ****************************************************************
  // falling-edge sample and final register
  // ****************************************************************
  always_ff @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) neg_reg <= RST_BIT;
    else         neg_reg <= d_i;
  end

  // async modes act regardless of enable, sync modes need it
  assign q_next = a_set ? 1'b1 :
                  a_rst ? 1'b0 :
                  !ce_on ? q_reg :
                  s_set ? 1'b1 :
                  s_rst ? 1'b0 : sel_d;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) q_reg <= RST_BIT;
    else         q_reg <= q_next;
  end

  assign q_o = q_reg;

endmodule : iolg_pin_reg

// *** rtl/iolg_top.sv ***
// pin i/o logic cell: delay control, pin registers, edge monitor and gearbox
// Operation
// - delay line has 128 steps of 30 ps, about 3.81 ns at most.
// - delay code comes from a fixed value or run-time inc/dec control.
// - delay serves the input path or the output path, never both.
// - three storage elements: input capture, output hold, output enable.
// - register clock enable selectable active low or active high.
// - each register triggers on rising or falling edge.
// - local set/reset is sync set, sync reset, async set, async reset or none; all act on the rising edge, async ones ignore enable.
// - latch select only cancels the falling-edge option; each storage element stays a flip-flop.
// - edge monitor samples around the clock edge in double-rate mode.
// - pin is input, output, bidirectional or enable-gated tristate output.
// - basic mode passes enable, outgoing and incoming data without register stage.
// - single-rate mode puts the pin registers in all three paths.
// - double-rate input presents two pad bits per core clock.
// - double-rate output emits two core bits per core clock.
// - 4-bit deserialize gathers four pad bits per core clock.
// - 4-bit serialize shifts one four-bit word per core clock.
// - video receive deserializes seven pad bits per core clock.
// - video transmit serializes one seven-bit word per core clock.
// - 8-bit modes deserialize and serialize eight bits per core clock.
// - 10-bit modes deserialize and serialize ten bits per core clock.
// - 7, 8, 10 bit receive borrow neighbour; borrowed pin allows basic or single-rate only.
// - 16-bit gearbox modes exist only on the largest device.
module iolg_top
  import iolg_pkg::*;
#(
  parameter bit LARGE_DEVICE = 1'b0
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // pad side
  input  wire logic        pad_in_i,
  output logic             pad_out_o,
  output logic             pad_oe_o,
  // configuration
  input  wire iolg_mode_t  mode_i,
  input  wire iolg_dir_t   dir_i,
  input  wire logic        ce_act_high_i,
  input  wire logic        in_fall_edge_i,
  input  wire logic        out_fall_edge_i,
  input  wire iolg_sr_t    in_sr_mode_i,
  input  wire iolg_sr_t    out_sr_mode_i,
  input  wire logic        latch_i,
  input  wire logic        nbr_borrowed_i,
  // delay control
  input  wire logic [6:0]  dly_static_i,
  input  wire logic        dly_dyn_en_i,
  input  wire logic        dly_inc_i,
  input  wire logic        dly_dec_i,
  input  wire logic        dly_on_out_i,
  // core side
  input  wire logic        in_ce_i,
  input  wire logic        out_ce_i,
  input  wire logic        in_side_set_reset_i,
  input  wire logic        out_side_set_reset_i,
  input  wire logic        core_out_bit_i,
  input  wire logic        core_oe_i,
  input  wire logic [15:0] tx_word_i,
  output logic             incoming_bit_o,
  output logic [15:0]      rx_word_o,
  output logic             core_stb_o,
  // status
  output logic [6:0]       in_dly_taps_o,
  output logic [6:0]       out_dly_taps_o,
  output logic [11:0]      dly_ps_o,
  output logic             edge_monitor_o,
  output logic             nbr_claim_o,
  output logic             mode_err_o
);

  // ****************************************************************
  // pad input synchroniser
  // ****************************************************************
  logic pad_s1_reg;
  logic pad_s2_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pad_s1_reg <= RST_BIT;
      pad_s2_reg <= RST_BIT;
    end else begin
      pad_s1_reg <= pad_in_i;
      pad_s2_reg <= pad_s1_reg;
    end
  end

  // ****************************************************************
  // mode check
  // ****************************************************************
  iolg_mode_t mode_reg;
  logic       mode_err_reg;
  wire        req_basic_sdr = (mode_i == MD_BASIC) || (mode_i == MD_SDR);
  wire        bad_big       = (mode_i == MD_GB16) && !LARGE_DEVICE;
  wire        bad_borrow    = nbr_borrowed_i && !req_basic_sdr;
  wire        mode_ok       = !bad_big && !bad_borrow;
  wire        in_side       = (dir_i == DIR_IN) || (dir_i == DIR_BIDIR);
  wire        out_side      = (dir_i != DIR_IN);
  wire        is_basic      = (mode_reg == MD_BASIC);
  wire        is_sdr        = (mode_reg == MD_SDR);
  wire        is_gear       = !is_basic && !is_sdr;
  wire        is_borrow     = (mode_reg == MD_GB7) || (mode_reg == MD_GB8) || (mode_reg == MD_GB10);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg     <= MD_BASIC;
      mode_err_reg <= RST_BIT;
    end else begin
      mode_reg     <= mode_ok ? mode_i : MD_BASIC;
      mode_err_reg <= !mode_ok;
    end
  end

  // ****************************************************************
  // delay line control
  // ****************************************************************
  logic [6:0] dly_code_reg;
  logic [6:0] dly_code_next;
  wire        dly_up = dly_inc_i && !dly_dec_i && (dly_code_reg != DLY_MAX);
  wire        dly_dn = dly_dec_i && !dly_inc_i && (dly_code_reg != DLY_MIN);

  assign dly_code_next = !dly_dyn_en_i ? dly_static_i :
                         dly_up ? dly_code_reg + 7'h01 :
                         dly_dn ? dly_code_reg - 7'h01 : dly_code_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_code_reg   <= DLY_RST;
      in_dly_taps_o  <= DLY_RST;
      out_dly_taps_o <= DLY_RST;
      dly_ps_o       <= 12'h000;
    end else begin
      dly_code_reg   <= dly_code_next;
      in_dly_taps_o  <= dly_on_out_i ? DLY_MIN : dly_code_next;
      out_dly_taps_o <= dly_on_out_i ? dly_code_next : DLY_MIN;
      dly_ps_o       <= dly_ps(dly_code_next);
    end
  end

  // ****************************************************************
  // pin registers
  // ****************************************************************
  logic in_q;
  logic out_q;
  logic oe_q;

  // input capture flop
  iolg_pin_reg u_input_capture_flop (
    .clk_i         (clk_i),
    .nrst_i        (nrst_i),
    .d_i           (pad_s2_reg),
    .q_o           (in_q),
    .ce_i          (in_ce_i),
    .ce_act_high_i (ce_act_high_i),
    .fall_edge_i   (in_fall_edge_i),
    .sr_i          (in_side_set_reset_i),
    .sr_mode_i     (in_sr_mode_i),
    .latch_i       (latch_i)
  );

  iolg_pin_reg u_output_hold_flop (
    .clk_i         (clk_i),
    .nrst_i        (nrst_i),
    .d_i           (core_out_bit_i),
    .q_o           (out_q),
    .ce_i          (out_ce_i),
    .ce_act_high_i (ce_act_high_i),
    .fall_edge_i   (out_fall_edge_i),
    .sr_i          (out_side_set_reset_i),
    .sr_mode_i     (out_sr_mode_i),
    .latch_i       (latch_i)
  );

  iolg_pin_reg u_output_enable_flop (
    .clk_i         (clk_i),
    .nrst_i        (nrst_i),
    .d_i           (core_oe_i),
    .q_o           (oe_q),
    .ce_i          (out_ce_i),
    .ce_act_high_i (ce_act_high_i),
    .fall_edge_i   (out_fall_edge_i),
    .sr_i          (out_side_set_reset_i),
    .sr_mode_i     (out_sr_mode_i),
    .latch_i       (latch_i)
  );

  // ****************************************************************
  // edge monitor
  // ****************************************************************
  logic em_s1_reg;
  logic em_s2_reg;
  logic em_neg_reg;

  // falling-edge copy of the pad through its own two-stage synchroniser;
  // the extra stage lines it up with the falling edge just before the rising sample
  always_ff @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      em_s1_reg  <= RST_BIT;
      em_s2_reg  <= RST_BIT;
      em_neg_reg <= RST_BIT;
    end else begin
      em_s1_reg  <= pad_in_i;
      em_s2_reg  <= em_s1_reg;
      em_neg_reg <= em_s2_reg;
    end
  end

  // ****************************************************************
  // gearbox rate counter and shifters
  // ****************************************************************
  logic [3:0]  bit_cnt_reg;
  logic [15:0] rx_sh_reg;
  logic [15:0] tx_sh_reg;
  wire  [4:0]  ratio_w   = ratio_of(mode_reg);
  wire         stb_w     = ({1'b0, bit_cnt_reg} == (ratio_w - 5'h01));
  wire  [3:0]  cnt_next  = stb_w ? 4'h0 : bit_cnt_reg + 4'h1;
  wire  [15:0] rx_sh_nx  = {pad_s2_reg, rx_sh_reg[15:1]};
  wire  [15:0] rx_word_w = take_word(rx_sh_nx, ratio_w);
  wire  [15:0] tx_sh_nx  = stb_w ? tx_word_i : {1'b0, tx_sh_reg[15:1]};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_reg <= 4'h0;
      rx_sh_reg   <= RST_WORD;
      tx_sh_reg   <= RST_WORD;
    end else begin
      bit_cnt_reg <= cnt_next;
      rx_sh_reg   <= rx_sh_nx;
      tx_sh_reg   <= tx_sh_nx;
    end
  end

  // ****************************************************************
  // core side outputs
  // ****************************************************************
  // word update once per core clock
  wire [15:0] rx_word_nx = (is_gear && in_side && stb_w) ? rx_word_w : rx_word_o;
  wire        in_bit_nx  = is_sdr ? in_q : pad_s2_reg;
  wire        em_nx      = (mode_reg == MD_DDR) && (pad_s2_reg != em_neg_reg);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_word_o      <= RST_WORD;
      incoming_bit_o <= RST_BIT;
      core_stb_o     <= RST_BIT;
      edge_monitor_o <= RST_BIT;
      nbr_claim_o    <= RST_BIT;
      mode_err_o     <= RST_BIT;
    end else begin
      rx_word_o      <= rx_word_nx;
      incoming_bit_o <= in_bit_nx;
      core_stb_o     <= stb_w;
      edge_monitor_o <= em_nx;
      nbr_claim_o    <= is_borrow && in_side;
      mode_err_o     <= mode_err_reg;
    end
  end

  // ****************************************************************
  // pad side outputs
  // ****************************************************************
  // serial bit: word lsb first
  wire ser_bit  = stb_w ? tx_word_i[0] : tx_sh_reg[1];
  wire out_nx   = is_gear ? ser_bit : (is_sdr ? out_q : core_out_bit_i);
  wire oe_src   = is_sdr ? oe_q : core_oe_i;
  wire oe_nx    = (dir_i == DIR_IN)  ? 1'b0 :
                  (dir_i == DIR_OUT) ? 1'b1 : oe_src;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pad_out_o <= RST_BIT;
      pad_oe_o  <= RST_BIT;
    end else begin
      pad_out_o <= out_side ? out_nx : 1'b0;
      pad_oe_o  <= oe_nx;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_dly_saturate: assert property (dly_dyn_en_i && dly_code_reg == DLY_MAX && dly_inc_i && !dly_dec_i
                                   |=> dly_code_reg == DLY_MAX)
    else $error("delay code wrapped past top step");
  a_dly_static: assert property (!dly_dyn_en_i |=> dly_code_reg == $past(dly_static_i))
    else $error("static delay code not applied");
  a_dly_one_path: assert property (in_dly_taps_o == DLY_MIN || out_dly_taps_o == DLY_MIN)
    else $error("delay applied to both paths");
  a_in_dir_hiz: assert property (dir_i == DIR_IN |=> !pad_oe_o)
    else $error("input pin drives pad");
  a_gb4_period: assert property ((mode_reg == MD_GB4 && core_stb_o) ##1 (mode_reg == MD_GB4)[*4]
                                 |-> core_stb_o)
    else $error("4-bit core strobe period wrong");
  a_ddr_word: assert property (mode_reg == MD_DDR && in_side && stb_w
                               |=> rx_word_o[1] == $past(pad_s2_reg) && rx_word_o[0] == $past(pad_s2_reg, 2))
    else $error("double-rate word bits wrong");
  a_ser_load: assert property (is_gear && out_side && stb_w |=> pad_out_o == $past(tx_word_i[0]))
    else $error("serializer first bit wrong");
  a_borrow_mode: assert property ($past(nbr_borrowed_i) |-> is_basic || is_sdr)
    else $error("borrowed pin in gearbox mode");
  a_no_big_gb: assert property (!LARGE_DEVICE |-> mode_reg != MD_GB16)
    else $error("16-bit mode on small device");

  c_gb10_word: cover property (mode_reg == MD_GB10 && core_stb_o);
  c_ddr_edge: cover property (edge_monitor_o);
  c_dly_top: cover property (dly_code_reg == DLY_MAX);
  c_mode_err: cover property (mode_err_o);

endmodule : iolg_top

// *** bench/iolg_pad_partner.sv ***
// pad-side partner: drives the input pad and logs every bit it drives on the rising edge
module iolg_pad_partner (
  // clock
  input  wire logic clk_i,
  // control from the bench
  input  wire logic drive_i,
  input  wire logic bit_i,
  input  wire logic skew_i,
  // pad
  output logic      pad_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // pad driver
  // ********
  logic hist[$];

  initial pad_o = 1'b0;

  // a released line shows the inverse of its last level, never a stale copy
  always @(posedge clk_i) begin
    hist.push_back(drive_i ? bit_i : ~pad_o);
    pad_o <= drive_i ? bit_i : ~pad_o;
  end

  // late transition just past the falling edge, seen only by the rising-edge pad synchroniser
  always @(negedge clk_i) begin
    if (skew_i) pad_o <= #1 ~pad_o;
  end
endmodule : iolg_pad_partner

// *** bench/tb.sv ***
// self-checking bench for the pin i/o logic cell
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iolg_pkg::*;

  // ********
  // signals
  // ********
  logic        clk_i, nrst_i, pad_in_i, pad_out_o, pad_oe_o;
  iolg_mode_t  mode_i;
  iolg_dir_t   dir_i;
  iolg_sr_t    in_sr_mode_i, out_sr_mode_i;
  logic        ce_act_high_i, in_fall_edge_i, out_fall_edge_i, latch_i, nbr_borrowed_i;
  logic [6:0]  dly_static_i, in_dly_taps_o, out_dly_taps_o;
  logic        dly_dyn_en_i, dly_inc_i, dly_dec_i, dly_on_out_i, in_ce_i, out_ce_i;
  logic        in_side_set_reset_i, out_side_set_reset_i, core_out_bit_i, core_oe_i;
  logic [15:0] tx_word_i, rx_word_o, ew, cw;
  logic        incoming_bit_o, core_stb_o, edge_monitor_o, nbr_claim_o, mode_err_o;
  logic [11:0] dly_ps_o;
  logic        pad_bit, pad_drv, pad_skew;
  logic [1:0]  m;
  logic [31:0] seed = 32'h0dfa;
  logic [31:0] tseed = 32'h0dfa;
  logic [1:0]  bq[$];
  logic [15:0] wq[$];
  int          mismatches, check_count, ph, cur_r, lat, idx, last, em_hits;
  int          cyc = 0;
  iolg_mode_t  gm[5] = '{MD_DDR, MD_GB4, MD_GB7, MD_GB8, MD_GB10};
  logic [4:0]  gr[5] = '{RATIO_DDR, RATIO_GB4, RATIO_GB7, RATIO_GB8, RATIO_GB10};
  wire  [48:0] outs = {pad_out_o, pad_oe_o, core_stb_o, mode_err_o, nbr_claim_o, edge_monitor_o,
                       incoming_bit_o, rx_word_o, in_dly_taps_o, out_dly_taps_o, dly_ps_o};

  iolg_top #(.LARGE_DEVICE(1'b0)) u_dut (
    .clk_i, .nrst_i, .pad_in_i, .pad_out_o, .pad_oe_o, .mode_i, .dir_i, .ce_act_high_i,
    .in_fall_edge_i, .out_fall_edge_i, .in_sr_mode_i, .out_sr_mode_i, .latch_i, .nbr_borrowed_i,
    .dly_static_i, .dly_dyn_en_i, .dly_inc_i, .dly_dec_i, .dly_on_out_i, .in_ce_i, .out_ce_i,
    .in_side_set_reset_i, .out_side_set_reset_i, .core_out_bit_i, .core_oe_i, .tx_word_i,
    .incoming_bit_o, .rx_word_o, .core_stb_o, .in_dly_taps_o, .out_dly_taps_o, .dly_ps_o,
    .edge_monitor_o, .nbr_claim_o, .mode_err_o
  );

  iolg_pad_partner u_pad (.clk_i, .drive_i(pad_drv), .bit_i(pad_bit), .skew_i(pad_skew), .pad_o(pad_in_i));

  // ********
  // helpers
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // random pad and core bits; in pipe phases also enable, set/reset and the expected pad pair
  task automatic cycles(input int n);
    logic en, sr;
    repeat (n) begin
      @(posedge clk_i);
      seed = lfsr(seed);
      pad_bit <= seed[0];
      core_out_bit_i <= seed[1];
      core_oe_i <= seed[2];
      if (ph == 3) begin
        en = (seed[4:3] != 2'h0) || (bq.size() == 0);
        sr = (seed[6:5] == 2'h0);
        out_ce_i <= en ~^ ce_act_high_i;
        in_ce_i <= ce_act_high_i;
        out_side_set_reset_i <= sr;
        if (lat == 1) m = {seed[1], seed[2]};
        else if (en) m = sr ? 2'b00 : {seed[1], seed[2]};
        bq.push_back(m);
      end
    end
  endtask : cycles

  // ********
  // clock, watchdog, drivers and monitor
  // ********
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    #20us;
    mismatches++;
    conclude();
  end

  always @(posedge clk_i) cyc <= cyc + 1;

  // serializer feed: a new word just after each strobe, noted for the monitor
  always @(posedge clk_i) begin
    if (ph == 2 && core_stb_o === 1'b1) begin
      tseed = lfsr(tseed);
      tx_word_i <= tseed[31:16];
      wq.push_back(tseed[31:16]);
    end
  end

  always @(negedge clk_i) begin
    if (edge_monitor_o === 1'b1) em_hits++;
    if (ph == 1 && core_stb_o === 1'b1) begin
      ew = '0;
      for (int i = 0; i < cur_r; i++) ew[i] = u_pad.hist[u_pad.hist.size() - 3 - cur_r + i];
      if (last > 0) chk(cyc - last, cur_r);
      last = cyc;
      chk(rx_word_o, ew);
    end
    if (ph == 2) begin
      if (core_stb_o === 1'b1 && wq.size() > 0) begin
        cw = wq.pop_front();
        idx = 0;
      end
      if (idx < cur_r) begin
        chk(pad_out_o, cw[idx]);
        idx++;
      end
    end
    if (ph == 3 && bq.size() > lat) chk(incoming_bit_o, u_pad.hist[u_pad.hist.size() - 3 - lat]);
    if (ph == 3 && bq.size() > lat) chk({pad_out_o, pad_oe_o}, bq.pop_front());
  end

  initial begin
    {nrst_i, ce_act_high_i, in_fall_edge_i, out_fall_edge_i, latch_i, nbr_borrowed_i, dly_static_i,
     dly_dyn_en_i, dly_inc_i, dly_dec_i, dly_on_out_i, in_ce_i, out_ce_i, in_side_set_reset_i,
     out_side_set_reset_i, core_out_bit_i, core_oe_i, tx_word_i, pad_bit, pad_skew} = '0;
    pad_drv = 1'b1;
    mode_i = MD_BASIC;
    dir_i = DIR_IN;
    in_sr_mode_i = SR_NONE;
    out_sr_mode_i = SR_NONE;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(outs, 49'h0);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    chk(outs, 49'h0);
    $display("test reset done");
    cycles(1);
    dly_dyn_en_i <= 1'b1;
    dly_inc_i <= 1'b1;
    cycles(130);
    dly_inc_i <= 1'b0;
    cycles(2);
    chk({in_dly_taps_o, out_dly_taps_o, dly_ps_o}, {DLY_MAX, DLY_MIN, 12'(127 * DLY_STEP_PS)});
    dly_on_out_i <= 1'b1;
    cycles(2);
    chk({in_dly_taps_o, out_dly_taps_o}, {DLY_MIN, DLY_MAX});
    dly_dec_i <= 1'b1;
    cycles(130);
    dly_dec_i <= 1'b0;
    cycles(2);
    chk({out_dly_taps_o, dly_ps_o}, 19'h0);
    dly_dyn_en_i <= 1'b0;
    dly_on_out_i <= 1'b0;
    repeat (4) begin
      dly_static_i <= seed[13:7];
      cycles(2);
      chk({in_dly_taps_o, dly_ps_o}, {dly_static_i, 12'(dly_static_i * DLY_STEP_PS)});
    end
    $display("test delay done");
    foreach (gm[i]) begin
      mode_i <= gm[i];
      cur_r = int'(gr[i]);
      cycles(12);
      last = 0;
      ph = 1;
      cycles(6 * cur_r);
      ph = 0;
    end
    $display("test deserialize done");
    dir_i <= DIR_OUT;
    pad_drv <= 1'b0;
    foreach (gm[i]) begin
      mode_i <= gm[i];
      cur_r = int'(gr[i]);
      cycles(12);
      wq.delete();
      idx = 99;
      ph = 2;
      cycles(6 * cur_r);
      ph = 0;
    end
    $display("test serialize done");
    dir_i <= DIR_BIDIR;
    mode_i <= MD_BASIC;
    out_sr_mode_i <= SR_SRST;
    for (int k = 0; k < 9; k++) begin
      if (k > 0) mode_i <= MD_SDR;
      {ce_act_high_i, latch_i, out_fall_edge_i} <= 3'(k);
      lat = (k > 0) ? 2 : 1;
      cycles(4);
      bq.delete();
      ph = 3;
      cycles(30);
      ph = 0;
    end
    $display("test pin registers done");
    dir_i <= DIR_IN;
    pad_drv <= 1'b1;
    mode_i <= MD_GB16;
    cycles(3);
    chk(mode_err_o, 1'b1);
    mode_i <= MD_GB8;
    cycles(3);
    chk({mode_err_o, nbr_claim_o}, 2'b01);
    nbr_borrowed_i <= 1'b1;
    cycles(3);
    chk(mode_err_o, 1'b1);
    mode_i <= MD_SDR;
    cycles(3);
    chk(mode_err_o, 1'b0);
    nbr_borrowed_i <= 1'b0;
    mode_i <= MD_DDR;
    cycles(8);
    em_hits = 0;
    cycles(20);
    chk(em_hits, 0);
    pad_skew <= 1'b1;
    cycles(20);
    chk(em_hits != 0, 1'b1);
    $display("test modes and edge monitor done");
    conclude();
  end
endmodule : tb
